/* rtl/rtcpp_regs.vh */
// Register map, field positions, reset values and timing of the RTC control
`ifndef RTCPP_REGS_VH
`define RTCPP_REGS_VH

// ============================================================
// Register addresses (4-bit parallel bus)
`define RTCPP_ADDR_FREEZE_FLAG   4'hD
`define RTCPP_ADDR_PULSE_CTRL    4'hE
`define RTCPP_ADDR_CNT_FORMAT    4'hF
`define RTCPP_ADDR_TIME_LAST     4'hC

// ============================================================
// freeze_and_flag_control fields
`define RTCPP_FF_FREEZE          0
`define RTCPP_FF_BUSY            1
`define RTCPP_FF_FLAG            2
`define RTCPP_FF_ADJ             3

// pulse_output_control fields
`define RTCPP_PC_MASK            0
`define RTCPP_PC_MODE            1
`define RTCPP_PC_PSEL_LO         2
`define RTCPP_PC_PSEL_HI         3

// counter_format_control fields
`define RTCPP_CF_CRESET          0
`define RTCPP_CF_STOP            1
`define RTCPP_CF_HOUR24          2
`define RTCPP_CF_TEST            3

// ============================================================
// Reset values
`define RTCPP_PC_RESET           4'h1
`define RTCPP_CF_RESET           4'h0

// ============================================================
// Timing
`define RTCPP_CLK_HZ             20000000
`define RTCPP_CLK_PERIOD_NS      50
`define RTCPP_OSC_HZ             32768
`define RTCPP_BUSY_NS            190000
`define RTCPP_ADJ_NS             125000
`define RTCPP_PULSE_NS           7812500
`define RTCPP_PS_WIDTH           15
`define RTCPP_PS64_MASK          9'h1FF

`endif

/* rtl/rtcpp_osc_div.v */
// Fractional divider making the 32.768 kHz oscillator tick enable
`timescale 1ns/1ps
`default_nettype none

module rtcpp_osc_div #(
  parameter CLK_HZ = 20000000,
  parameter OSC_HZ = 32768
) (
  input  wire ref_clk_i,
  input  wire sys_rst_i,
  output reg  tick_o
);

  reg  [31:0] acc_r;
  wire [31:0] acc_sum;

  assign acc_sum = acc_r + OSC_HZ[31:0];

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_r  <= 32'h0;
      tick_o <= 1'b0;
    end else if (acc_sum >= CLK_HZ[31:0]) begin
      acc_r  <= acc_sum - CLK_HZ[31:0];
      tick_o <= 1'b1;
    end else begin
      acc_r  <= acc_sum;
      tick_o <= 1'b0;
    end
  end

endmodule // rtcpp_osc_div

`default_nettype wire

/* rtl/rtcpp_timer.v */
// Retriggerable one-shot timer: level while running, pulse at expiry
`timescale 1ns/1ps
`default_nettype none

module rtcpp_timer #(
  parameter W   = 18,
  parameter CYC = 3800
) (
  input  wire ref_clk_i,
  input  wire sys_rst_i,
  input  wire start_i,
  input  wire clr_i,
  output wire act_o,
  output reg  done_o
);

  reg [W-1:0] cnt_r;

  assign act_o = (cnt_r != {W{1'b0}});

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r  <= {W{1'b0}};
      done_o <= 1'b0;
    end else if (start_i) begin
      cnt_r  <= CYC[W-1:0];
      done_o <= 1'b0;
    end else if (clr_i) begin
      cnt_r  <= {W{1'b0}};
      done_o <= 1'b0;
    end else if (act_o) begin
      cnt_r  <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      done_o <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end else begin
      done_o <= 1'b0;
    end
  end

endmodule // rtcpp_timer

`default_nettype wire

/* rtl/rtcpp_top.v */
// RTC control registers, freeze handshake, prescaler and pulse output
//
// Operation
// R01: busy reads 1 while freeze is 0, 0 while freeze granted.
// R02: internal busy window of 190 us after each second carry.
// R03: host writes to the busy bit are ignored.
// R04: host sets freeze and checks busy before time register access.
// R05: the three control registers are accessible at any time.
// R06: interrupt flag reads 1 exactly while the pulse output is low.
// R07: with mask 0, the selected carry pulls output low and sets flag.
// R08: interrupt mode holds flag until host writes 0; new events ignored.
// R09: waveform mode clears flag on host 0 write or after 7.8125 ms.
// R10: adjust bit triggers 30 s compensation, reads 1 for 125 us.
// R11: host avoids time registers until the adjust bit returns to 0.
// R12: mask 1 releases the pulse output; mask 0 enables driving.
// R13: mode 1 gives interrupts, mode 0 a 7.8125 ms low waveform.
// R14: period select 00 1/64 s, 01 1 s, 10 minute, 11 hour.
// R15: adjust-caused carry in waveform mode holds low until next 1/64 s.
// R16: time register writes alone never change the pulse output.
// R17: counter reset holds the prescaler; chip select low clears it.
// R18: stop bit halts the stages from 8192 Hz onward.
// R19: hour-format 1 selects 24-hour, 0 selects 12-hour counting.
// R20: hour-format writes take effect only with counter reset 1.
// R21: host changes format with reset 1, then reset 0, then rewrites hours.
// R22: host keeps the test bit at 0.
// R23: freeze blocks second carries; one catch-up on release; CS clears.
`timescale 1ns/1ps
`default_nettype none
`include "rtcpp_regs.vh"

module rtcpp_top #(
  parameter CLK_HZ    = `RTCPP_CLK_HZ,
  parameter PULSE_CYC = `RTCPP_PULSE_NS / `RTCPP_CLK_PERIOD_NS
) (
  input  wire       ref_clk_i,
  input  wire       sys_rst_i,
  input  wire       cs0_n_i,
  input  wire       cs1_i,
  input  wire       ale_i,
  input  wire [3:0] addr_i,
  input  wire       wr_n_i,
  input  wire       rd_n_i,
  input  wire [3:0] data_i,
  output reg  [3:0] data_o,
  output reg        data_oe_o,
  output reg        pulse_o,
  output reg        pulse_oe_o,
  input  wire [3:0] time_rd_data_i,
  input  wire       min_carry_i,
  input  wire       hour_carry_i,
  output reg  [3:0] time_addr_o,
  output reg  [3:0] time_data_o,
  output reg        time_wr_o,
  output reg        sec_carry_o,
  output reg        adj30_o,
  output reg        hour24_o,
  output reg        stop_o,
  output reg        test_o
);

  localparam BUSY_CYC = (`RTCPP_BUSY_NS + `RTCPP_CLK_PERIOD_NS - 1) /
                        `RTCPP_CLK_PERIOD_NS;
  localparam ADJ_CYC  = (`RTCPP_ADJ_NS + `RTCPP_CLK_PERIOD_NS - 1) /
                        `RTCPP_CLK_PERIOD_NS;
  localparam PSW      = `RTCPP_PS_WIDTH;

  // ============================================================
  // Bus front end
  reg  [3:0] addr_q_r;
  reg  [3:0] wdata_r;
  reg        wr_eff_q_r;
  wire       cs_en;
  wire       wr_eff;
  wire       wr_rise;
  wire       wr_ff;
  wire       wr_pc;
  wire       wr_cf;
  wire       wr_time;

  assign cs_en   = cs1_i & ~cs0_n_i;
  assign wr_eff  = ~(cs_en & ~wr_n_i);
  assign wr_rise = wr_eff & ~wr_eff_q_r;
  assign wr_ff   = wr_rise & (addr_q_r == `RTCPP_ADDR_FREEZE_FLAG);
  assign wr_pc   = wr_rise & (addr_q_r == `RTCPP_ADDR_PULSE_CTRL);
  assign wr_cf   = wr_rise & (addr_q_r == `RTCPP_ADDR_CNT_FORMAT);
  assign wr_time = wr_rise & (addr_q_r <= `RTCPP_ADDR_TIME_LAST);

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_q_r   <= 4'h0;
      wdata_r    <= 4'h0;
      wr_eff_q_r <= 1'b1;
    end else begin
      wr_eff_q_r <= wr_eff;
      if (ale_i && cs_en) begin
        addr_q_r <= addr_i;
      end
      if (!wr_eff) begin
        wdata_r <= data_i;
      end
    end
  end

  // ============================================================
  // Control registers
  reg        freeze_r;
  reg  [3:0] pc_r;
  reg        creset_r;
  wire       mask;
  wire       mode_irq;
  wire [1:0] psel;
  wire       freeze_nxt;
  wire       freeze_fall;

  assign mask     = pc_r[`RTCPP_PC_MASK];
  assign mode_irq = pc_r[`RTCPP_PC_MODE];
  assign psel     = {pc_r[`RTCPP_PC_PSEL_HI], pc_r[`RTCPP_PC_PSEL_LO]};

  assign freeze_nxt  = !cs1_i ? 1'b0 :                               // R23
                       wr_ff ? wdata_r[`RTCPP_FF_FREEZE] : freeze_r;
  assign freeze_fall = freeze_r & ~freeze_nxt;

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      freeze_r <= 1'b0;
      pc_r     <= `RTCPP_PC_RESET;
      creset_r <= 1'b0;
      stop_o   <= 1'b0;
      hour24_o <= 1'b0;
      test_o   <= 1'b0;
    end else begin
      freeze_r <= freeze_nxt;
      if (wr_pc) begin
        pc_r <= wdata_r;                                             // R05
      end
      if (!cs1_i) begin
        creset_r <= 1'b0;                                            // R17
      end else if (wr_cf) begin
        creset_r <= wdata_r[`RTCPP_CF_CRESET];                       // R17
      end
      if (wr_cf) begin
        stop_o <= wdata_r[`RTCPP_CF_STOP];                           // R18
        test_o <= wdata_r[`RTCPP_CF_TEST];
      end
      if (wr_cf && (creset_r || wdata_r[`RTCPP_CF_CRESET])) begin    // R20
        hour24_o <= wdata_r[`RTCPP_CF_HOUR24];                       // R19
      end
    end
  end

  // ============================================================
  // Sub-second prescaler
  wire           osc_tick;
  reg  [PSW-1:0] ps_r;
  wire           ps_adv_lo;
  wire           ps_adv_hi;
  wire           ps64;
  wire           ps1;

  rtcpp_osc_div #(
    .CLK_HZ (CLK_HZ),
    .OSC_HZ (`RTCPP_OSC_HZ)
  ) u_osc_div (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (osc_tick)
  );

  // Stages from 8192 Hz up advance only when not stopped
  assign ps_adv_lo = osc_tick & ~creset_r;
  assign ps_adv_hi = ps_adv_lo & (ps_r[1:0] == 2'h3) & ~stop_o;     // R18
  assign ps64 = ps_adv_hi & (ps_r[8:0] == `RTCPP_PS64_MASK);
  assign ps1  = ps_adv_hi & (ps_r == {PSW{1'b1}});

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ps_r <= {PSW{1'b0}};
    end else if (creset_r) begin
      ps_r <= {PSW{1'b0}};                                           // R17
    end else if (ps_adv_hi) begin
      ps_r <= ps_r + {{(PSW-1){1'b0}}, 1'b1};
    end else if (ps_adv_lo) begin
      ps_r[1:0] <= ps_r[1:0] + 2'h1;
    end
  end

  // ============================================================
  // Freeze handshake and second carry
  reg  frozen_r;
  reg  pend_r;
  wire busy_win;

  rtcpp_timer #(
    .W   (12),
    .CYC (BUSY_CYC)
  ) u_busy_tmr (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (ps1),                                                // R02
    .clr_i     (1'b0),
    .act_o     (busy_win),
    .done_o    ()
  );

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frozen_r    <= 1'b0;
      pend_r      <= 1'b0;
      sec_carry_o <= 1'b0;
    end else begin
      if (!freeze_nxt) begin
        frozen_r <= 1'b0;                                            // R01
      end else if (wr_ff && !busy_win) begin
        frozen_r <= 1'b1;                                            // R01
      end
      if (freeze_fall) begin
        sec_carry_o <= pend_r | ps1;                                 // R23
        pend_r      <= 1'b0;
      end else if (freeze_r) begin
        sec_carry_o <= 1'b0;                                         // R23
        pend_r      <= pend_r | ps1;
      end else begin
        sec_carry_o <= ps1;
        pend_r      <= 1'b0;
      end
    end
  end

  // ============================================================
  // Thirty-second adjust
  wire adj_start;
  wire adj_act;

  assign adj_start = wr_ff & wdata_r[`RTCPP_FF_ADJ];

  rtcpp_timer #(
    .W   (12),
    .CYC (ADJ_CYC)
  ) u_adj_tmr (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (adj_start),                                          // R10
    .clr_i     (1'b0),
    .act_o     (adj_act),
    .done_o    ()
  );

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      adj30_o <= 1'b0;
    end else begin
      adj30_o <= adj_start;                                          // R10
    end
  end

  // ============================================================
  // Pulse output and interrupt flag
  reg  flag_r;
  reg  adj_hold_r;
  reg  evt;
  wire flag_set;
  wire flag_clr;
  wire flag_nxt;
  wire pw_done;

  always @* begin
    case (psel)                                                      // R14
      2'h0:    evt = ps64;
      2'h1:    evt = ps1;
      2'h2:    evt = min_carry_i;
      2'h3:    evt = hour_carry_i;
      default: evt = 1'b0;
    endcase
  end

  assign flag_set = ~mask & ~flag_r & evt;                           // R07 R08
  assign flag_clr = (wr_ff & ~wdata_r[`RTCPP_FF_FLAG]) |             // R08
                    (~mode_irq & pw_done & ~adj_hold_r) |            // R09
                    (~mode_irq & adj_hold_r & ps64);                 // R15
  // Set wins over clear; mask releases the output at once
  assign flag_nxt = flag_set ? 1'b1 :
                    (flag_clr | mask) ? 1'b0 : flag_r;               // R12

  rtcpp_timer #(
    .W   (18),
    .CYC (PULSE_CYC)
  ) u_pw_tmr (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (flag_set),                                           // R13
    .clr_i     (~flag_r),
    .act_o     (),
    .done_o    (pw_done)
  );

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_r     <= 1'b0;
      adj_hold_r <= 1'b0;
      pulse_o    <= 1'b0;
      pulse_oe_o <= 1'b0;
    end else begin
      flag_r     <= flag_nxt;
      pulse_o    <= 1'b0;
      pulse_oe_o <= flag_nxt;                                        // R06
      if (!flag_nxt) begin
        adj_hold_r <= 1'b0;
      end else if (flag_set && !mode_irq && adj_act && psel[1]) begin
        adj_hold_r <= 1'b1;                                          // R15
      end
    end
  end

  // ============================================================
  // Time register pass-through and read-back
  reg [3:0] rd_mux;

  always @* begin
    case (addr_q_r)
      `RTCPP_ADDR_FREEZE_FLAG:
        rd_mux = {adj_act, flag_r, ~frozen_r, freeze_r};             // R01 R03
      `RTCPP_ADDR_PULSE_CTRL:
        rd_mux = pc_r;
      `RTCPP_ADDR_CNT_FORMAT:
        rd_mux = {test_o, hour24_o, stop_o, creset_r};
      default:
        rd_mux = time_rd_data_i;
    endcase
  end

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_o      <= 4'h0;
      data_oe_o   <= 1'b0;
      time_addr_o <= 4'h0;
      time_data_o <= 4'h0;
      time_wr_o   <= 1'b0;
    end else begin
      data_o      <= rd_mux;
      data_oe_o   <= cs_en & ~rd_n_i & wr_n_i;
      time_addr_o <= addr_q_r;
      time_data_o <= wdata_r;
      time_wr_o   <= wr_time;                                        // R16
    end
  end

endmodule // rtcpp_top

`default_nettype wire

/* verification/rtcpp_checker.sv */
// Port-level assertions for the RTC control block
`timescale 1ns/1ps
`default_nettype none
module rtcpp_checker #(
  parameter CLK_HZ    = 20000000,
  parameter PULSE_CYC = 156250
) (
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       cs0_n_i,
  input wire logic       cs1_i,
  input wire logic       wr_n_i,
  input wire logic       rd_n_i,
  input wire logic [3:0] data_o,
  input wire logic       data_oe_o,
  input wire logic       pulse_o,
  input wire logic       pulse_oe_o,
  input wire logic [3:0] time_addr_o,
  input wire logic       time_wr_o,
  input wire logic       adj30_o,
  input wire logic       hour24_o,
  input wire logic       stop_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========
  // Pulse pin and status mirror
  property p_pulse_low; pulse_oe_o |-> !pulse_o; endproperty
  a_pulse_low: assert property (p_pulse_low)
    else $error("pulse pin driven high");
  property p_flag_pin;
    data_oe_o && time_addr_o == 4'hD |->
      data_o[2] == pulse_oe_o || data_o[2] == $past(pulse_oe_o);
  endproperty
  a_flag_pin: assert property (p_flag_pin)
    else $error("flag differs from pin");
  property p_busy_free;
    data_oe_o && time_addr_o == 4'hD && !data_o[0] |-> data_o[1];
  endproperty
  a_busy_free: assert property (p_busy_free)
    else $error("busy low without freeze");
  // ==========
  // Bus and strobes
  property p_oe;
    data_oe_o == $past(cs1_i && !cs0_n_i && !rd_n_i && wr_n_i);
  endproperty
  a_oe: assert property (p_oe)
    else $error("data drive enable wrong");
  property p_adj_once; adj30_o |=> !adj30_o; endproperty
  a_adj_once: assert property (p_adj_once)
    else $error("adjust pulse too long");
  property p_adj_addr; adj30_o |-> time_addr_o == 4'hD; endproperty
  a_adj_addr: assert property (p_adj_addr)
    else $error("adjust without status write");
  property p_twr_addr; time_wr_o |-> time_addr_o <= 4'hC; endproperty
  a_twr_addr: assert property (p_twr_addr)
    else $error("time write outside time range");
  property p_twr_quiet; time_wr_o |=> $stable(pulse_oe_o); endproperty
  a_twr_quiet: assert property (p_twr_quiet)
    else $error("time write moved pulse pin");
  property p_h24; $changed(hour24_o) |-> time_addr_o == 4'hF; endproperty
  a_h24: assert property (p_h24)
    else $error("hour format changed unasked");
  property p_stop; $changed(stop_o) |-> time_addr_o == 4'hF; endproperty
  a_stop: assert property (p_stop)
    else $error("stop changed unasked");
endmodule // rtcpp_checker
bind rtcpp_top rtcpp_checker #(.CLK_HZ(CLK_HZ), .PULSE_CYC(PULSE_CYC))
  u_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cs0_n_i(cs0_n_i),
    .cs1_i(cs1_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .pulse_o(pulse_o), .pulse_oe_o(pulse_oe_o),
    .time_addr_o(time_addr_o), .time_wr_o(time_wr_o), .adj30_o(adj30_o),
    .hour24_o(hour24_o), .stop_o(stop_o));
`default_nettype wire

/* verification/rtcpp_time_model.sv */
// Time counter model behind the control block's time bus
`timescale 1ns/1ps
`default_nettype none
module rtcpp_time_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [3:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       min_req_i,
  input  wire logic       hour_req_i,
  output logic      [3:0] rdata_o,
  output logic            min_carry_o,
  output logic            hour_carry_o
);
  logic [3:0] nib_r [0:12];
  assign rdata_o = (addr_i <= 4'hC) ? nib_r[addr_i] : 4'h0;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 13; i++) nib_r[i] <= 4'h0;
      min_carry_o <= 1'b0;
      hour_carry_o <= 1'b0;
    end else begin
      if (wr_i && addr_i <= 4'hC) nib_r[addr_i] <= wdata_i;
      min_carry_o <= min_req_i;
      hour_carry_o <= hour_req_i;
    end
  end
endmodule // rtcpp_time_model
`default_nettype wire

/* verification/rtcpp_top_test.sv */
// Self-checking bench for the RTC control and pulse output block
`timescale 1ns/1ps
`default_nettype none
module rtcpp_top_test;
  logic       ref_clk_i, sys_rst_i, cs0_n_i, cs1_i, ale_i, wr_n_i, rd_n_i;
  logic [3:0] addr_i, data_i, data_o, time_rd_data_i, time_addr_o;
  logic [3:0] time_data_o;
  logic       data_oe_o, pulse_o, pulse_oe_o, min_carry_i, hour_carry_i;
  logic       time_wr_o, sec_carry_o, adj30_o, hour24_o, stop_o, test_o;
  logic       mreq, hreq, adj_seen, twr_seen;
  int         error_cnt, total_checks, n, sec_cnt;
  rtcpp_top #(.CLK_HZ(65536), .PULSE_CYC(200)) dut (.*);
  rtcpp_time_model u_time (.clk_i(ref_clk_i), .rst_i(sys_rst_i),
    .addr_i(time_addr_o), .wdata_i(time_data_o), .wr_i(time_wr_o),
    .min_req_i(mreq), .hour_req_i(hreq), .rdata_o(time_rd_data_i),
    .min_carry_o(min_carry_i), .hour_carry_o(hour_carry_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      {adj_seen, twr_seen} <= 2'b00;
      sec_cnt <= 0;
    end else begin
      if (adj30_o === 1'b1) adj_seen <= 1'b1;
      if (time_wr_o === 1'b1) twr_seen <= 1'b1;
      if (sec_carry_o === 1'b1) sec_cnt <= sec_cnt + 1;
    end
  end
  // ==========
  // Bus tasks
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h got %0h", s, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    ale_i = 1'b1;
    addr_i = a;
    cyc(1);
    ale_i = 1'b0;
    data_i = d;
    wr_n_i = 1'b0;
    cyc(1);
    wr_n_i = 1'b1;
    cyc(2);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [3:0] m, e);
    ale_i = 1'b1;
    addr_i = a;
    cyc(1);
    ale_i = 1'b0;
    rd_n_i = 1'b0;
    cyc(2);
    chk($sformatf("read %h", a), e, data_o & m);
    chk("data_oe", 1, data_oe_o);
    rd_n_i = 1'b1;
    cyc(1);
  endtask
  task automatic wait_hi(input int lim);
    n = 0;
    while (pulse_oe_o !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    chk("pulse_oe rise", 1, pulse_oe_o);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(95000);
    error_cnt++;
    final_report;
  end
  // ==========
  // Tests
  initial begin
    {cs0_n_i, ale_i, addr_i, data_i, mreq, hreq} = '0;
    {cs1_i, wr_n_i, rd_n_i, sys_rst_i} = 4'hF;
    {error_cnt, total_checks} = '0;
    cyc(20);
    sys_rst_i = 1'b0;
    cyc(1);
    rdc(4'hE, 4'hF, 4'h1);
    rdc(4'hF, 4'hF, 4'h0);
    rdc(4'hD, 4'hF, 4'h2);
    chk("pulse_oe reset", 0, pulse_oe_o);
    wr(4'hD, 4'h3);
    rdc(4'hD, 4'hF, 4'h1);
    wr(4'hE, 4'h1);
    rdc(4'hE, 4'hF, 4'h1);
    wr(4'hD, 4'h0);
    rdc(4'hD, 4'hF, 4'h2);
    wr(4'hE, 4'h2);
    wr(4'hD, 4'h0);
    wait_hi(1100);
    cyc(400);
    rdc(4'hD, 4'h4, 4'h4);
    wr(4'hD, 4'h5);
    rdc(4'hD, 4'h3, 4'h1);
    wr(4'h0, 4'h5);
    chk("time_wr", 1, twr_seen);
    rdc(4'h0, 4'hF, 4'h5);
    chk("held", 1, pulse_oe_o);
    wr(4'hD, 4'h0);
    chk("flag cleared", 0, pulse_oe_o);
    wr(4'hE, 4'h0);
    wr(4'hD, 4'h0);
    wait_hi(1100);
    n = 0;
    while (pulse_oe_o === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk("low width", 201, n);
    wait_hi(1100);
    cyc(20);
    wr(4'hE, 4'h1);
    chk("masked", 0, pulse_oe_o);
    for (int k = 0; k < 2; k++) begin
      wr(4'hE, k ? 4'hE : 4'hA);
      wr(4'hD, 4'h0);
      chk("no carry", 0, pulse_oe_o);
      mreq = (k == 0);
      hreq = (k == 1);
      cyc(1);
      {mreq, hreq} = 2'b00;
      cyc(3);
      chk("carry flag", 1, pulse_oe_o);
    end
    wr(4'hE, 4'h2);
    wr(4'hF, 4'h2);
    wr(4'hD, 4'h0);
    cyc(2100);
    chk("stop_o", 1, stop_o);
    chk("stopped", 0, pulse_oe_o);
    wr(4'hF, 4'h0);
    wait_hi(1100);
    wr(4'hF, 4'h1);
    wr(4'hD, 4'h1);
    cyc(1100);
    chk("prescaler held", 0, pulse_oe_o);
    cs1_i = 1'b0;
    cyc(3);
    cs1_i = 1'b1;
    cyc(1);
    rdc(4'hF, 4'h1, 4'h0);
    rdc(4'hD, 4'h3, 4'h2);
    wait_hi(1100);
    wr(4'hE, 4'h6);
    wr(4'hD, 4'h0);
    wait_hi(66000);
    chk("sec carry", 1, sec_carry_o);
    wr(4'hD, 4'h5);
    rdc(4'hD, 4'h7, 4'h7);
    wr(4'hD, 4'h4);
    cyc(3900);
    wr(4'hD, 4'h5);
    rdc(4'hD, 4'h7, 4'h5);
    wr(4'hD, 4'h4);
    wr(4'hF, 4'h4);
    chk("format refused", 0, hour24_o);
    wr(4'hF, 4'h5);
    wr(4'hF, 4'h4);
    chk("hour24", 1, hour24_o);
    rdc(4'hF, 4'hF, 4'h4);
    chk("test_o", 0, test_o);
    wr(4'hD, 4'hC);
    chk("adj pulse", 1, adj_seen);
    rdc(4'hD, 4'h8, 4'h8);
    cyc(2600);
    rdc(4'hD, 4'h8, 4'h0);
    chk("sec carries", 1, sec_cnt);
    final_report;
  end
endmodule // rtcpp_top_test
`default_nettype wire
